// ### inc/mot_defines.vh
// Register indices, field positions, reset values and trim scale constants for the trim bank.
`ifndef MOT_DEFINES_VH
`define MOT_DEFINES_VH

// ****************************************
// Register indices on the control port
// ****************************************
`define MOT_IDX_IQ_GAIN      3'h1
`define MOT_IDX_ENVELOPE_GAIN_CODE     3'h2
`define MOT_IDX_I_OFFSET     3'h3
`define MOT_IDX_Q_OFFSET     3'h4
`define MOT_IDX_TEST_INV     3'h5

// ****************************************
// Reset value of every register
// ****************************************
`define MOT_RESET_VALUE      8'h00

// ****************************************
// Writable bit masks
// ****************************************
`define MOT_MASK_IQ_GAIN     8'hff
`define MOT_MASK_ENVELOPE_GAIN_CODE    8'hf0
`define MOT_MASK_OFFSET      8'hf8
`define MOT_MASK_TEST_INV    8'hff

// ****************************************
// Field positions
// ****************************************
`define MOT_I_GAIN_MSB       7
`define MOT_I_GAIN_LSB       4
`define MOT_Q_GAIN_MSB       3
`define MOT_Q_GAIN_LSB       0
`define MOT_ENVELOPE_GAIN_CODE_MSB     7
`define MOT_ENVELOPE_GAIN_CODE_LSB     4
`define MOT_OFFSET_MSB       7
`define MOT_OFFSET_LSB       3
`define MOT_INV_HI_BIT       3
`define MOT_INV_LO_BIT       2
`define MOT_TEST_HI_MSB      7
`define MOT_TEST_HI_LSB      4
`define MOT_TEST_LO_MSB      1
`define MOT_TEST_LO_LSB      0

// ****************************************
// Trim scale, amplitude in thousandths
// ****************************************
`define MOT_AMP_UNITY        12'h3e8
`define MOT_IQ_AMP_STEP      5'h06
`define MOT_ENV_AMP_STEP     5'h12
`define MOT_IQ_STEP_MV       3
`define MOT_ENV_STEP_MV      9
`define MOT_OFFSET_STEP_MV   3

`endif

// ### logic/mot_gain_decode.v
// Signed gain code to relative amplitude in thousandths.
`timescale 1ns/1ps
`default_nettype none
`include "mot_defines.vh"

module mot_gain_decode (
	// Code and step
	input  wire [3:0]  i_code,
	input  wire [4:0]  i_step,
	// Amplitude
	output wire [11:0] o_amp
);

	wire signed [11:0] step_s;
	wire signed [11:0] code_s;
	wire signed [11:0] prod_s;

	assign step_s = {7'h00, i_step};
	// Code is sign-extended, so negative codes pull the amplitude below unity.
	assign code_s = {{8{i_code[3]}}, i_code};
	assign prod_s = step_s * code_s;
	assign o_amp  = `MOT_AMP_UNITY + prod_s;

endmodule
`default_nettype wire

// ### logic/mot_trim_regs.v
// Output trim and IF-invert control register bank with decoded trim outputs.
`timescale 1ns/1ps
`default_nettype none
`include "mot_defines.vh"


module mot_trim_regs (
	// Clock and reset
	input  wire        i_clock,
	input  wire        i_reset,
	// Register write port
	input  wire        i_wr_en,
	input  wire [2:0]  i_wr_addr,
	input  wire [7:0]  i_wr_data,
	// Register read port
	input  wire [2:0]  i_rd_addr,
	output reg  [7:0]  o_rd_data,
	// Gain codes and amplitudes
	output reg  [3:0]  o_inphase_gain_code,
	output reg  [3:0]  o_quad_gain_code,
	output reg  [3:0]  o_envelope_gain_code,
	output reg  [11:0] o_inphase_amp,
	output reg  [11:0] o_quad_amp,
	output reg  [11:0] o_envelope_amp,
	// Offset codes and millivolts
	output reg  [4:0]  o_inphase_offset_code,
	output reg  [4:0]  o_quad_offset_code,
	output reg  [6:0]  o_inphase_offset_mv,
	output reg  [6:0]  o_quad_offset_mv,
	// Demodulator and test controls
	output reg         o_if_phase_invert_sel,
	output reg  [5:0]  o_factory_test_bits
);

	// ****************************************
	// Storage
	// ****************************************
	reg  [7:0]  iq_gain_trim_q;
	reg  [7:0]  envelope_gain_trim_q;
	reg  [7:0]  inphase_offset_trim_q;
	reg  [7:0]  quadrature_offset_trim_q;
	reg  [7:0]  test_and_if_invert_q;
	wire [11:0] inphase_amp_d;
	wire [11:0] quad_amp_d;
	wire [11:0] envelope_amp_d;

	// Offset code times three, kept as a shift and add of the sign-extended code.
	function [6:0] offset_mv;
		input [4:0] code;
		begin
			offset_mv = {{2{code[4]}}, code} + {code[4], code, 1'b0};
		end
	endfunction

	// Readback of one register by index; holes and index zero read as zero.
	function [7:0] reg_read;
		input [2:0] idx;
		begin
			case (idx)
				`MOT_IDX_IQ_GAIN:  reg_read = iq_gain_trim_q;
				`MOT_IDX_ENVELOPE_GAIN_CODE: reg_read = envelope_gain_trim_q;
				`MOT_IDX_I_OFFSET: reg_read = inphase_offset_trim_q;
				`MOT_IDX_Q_OFFSET: reg_read = quadrature_offset_trim_q;
				`MOT_IDX_TEST_INV: reg_read = test_and_if_invert_q;
				default:           reg_read = 8'h00;
			endcase
		end
	endfunction

	// ****************************************
	// Register writes
	// ****************************************
	// The write port is assumed to come from a serial front end on this same clock.
	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			iq_gain_trim_q           <= `MOT_RESET_VALUE;
			envelope_gain_trim_q     <= `MOT_RESET_VALUE;
			inphase_offset_trim_q    <= `MOT_RESET_VALUE;
			quadrature_offset_trim_q <= `MOT_RESET_VALUE;
			test_and_if_invert_q     <= `MOT_RESET_VALUE;
		end else if (i_wr_en) begin
			case (i_wr_addr)
				`MOT_IDX_IQ_GAIN: begin
					iq_gain_trim_q <= i_wr_data & `MOT_MASK_IQ_GAIN;
				end
				`MOT_IDX_ENVELOPE_GAIN_CODE: begin
					envelope_gain_trim_q <= i_wr_data & `MOT_MASK_ENVELOPE_GAIN_CODE;
				end
				`MOT_IDX_I_OFFSET: begin
					inphase_offset_trim_q <= i_wr_data & `MOT_MASK_OFFSET;
				end
				`MOT_IDX_Q_OFFSET: begin
					quadrature_offset_trim_q <= i_wr_data & `MOT_MASK_OFFSET;
				end
				`MOT_IDX_TEST_INV: begin
					test_and_if_invert_q <= i_wr_data & `MOT_MASK_TEST_INV;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Amplitude decode
	// ****************************************
	// in-phase signed amplitude
	mot_gain_decode u_inphase_amp (
		.i_code (iq_gain_trim_q[`MOT_I_GAIN_MSB:`MOT_I_GAIN_LSB]),
		.i_step (`MOT_IQ_AMP_STEP),
		.o_amp  (inphase_amp_d)
	);

	mot_gain_decode u_quad_amp (
		.i_code (iq_gain_trim_q[`MOT_Q_GAIN_MSB:`MOT_Q_GAIN_LSB]),
		.i_step (`MOT_IQ_AMP_STEP),
		.o_amp  (quad_amp_d)
	);

	mot_gain_decode u_envelope_amp (
		.i_code (envelope_gain_trim_q[`MOT_ENVELOPE_GAIN_CODE_MSB:`MOT_ENVELOPE_GAIN_CODE_LSB]),
		.i_step (`MOT_ENV_AMP_STEP),
		.o_amp  (envelope_amp_d)
	);

	// ****************************************
	// Registered outputs
	// ****************************************
	// Outputs lag the stored registers by one clock so every port comes from a flip-flop.
	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_rd_data             <= 8'h00;
			o_inphase_gain_code   <= 4'h0;
			o_quad_gain_code      <= 4'h0;
			o_envelope_gain_code  <= 4'h0;
			o_inphase_amp         <= `MOT_AMP_UNITY;
			o_quad_amp            <= `MOT_AMP_UNITY;
			o_envelope_amp        <= `MOT_AMP_UNITY;
			o_inphase_offset_code <= 5'h00;
			o_quad_offset_code    <= 5'h00;
			o_inphase_offset_mv   <= 7'h00;
			o_quad_offset_mv      <= 7'h00;
			o_if_phase_invert_sel <= 1'b0;
			o_factory_test_bits   <= 6'h00;
		end else begin
			o_rd_data             <= reg_read(i_rd_addr);
			o_inphase_gain_code   <= iq_gain_trim_q[`MOT_I_GAIN_MSB:`MOT_I_GAIN_LSB];
			o_quad_gain_code      <= iq_gain_trim_q[`MOT_Q_GAIN_MSB:`MOT_Q_GAIN_LSB];
			o_envelope_gain_code  <= envelope_gain_trim_q[`MOT_ENVELOPE_GAIN_CODE_MSB:`MOT_ENVELOPE_GAIN_CODE_LSB];
			o_inphase_amp         <= inphase_amp_d;
			o_quad_amp            <= quad_amp_d;
			o_envelope_amp        <= envelope_amp_d;
			o_inphase_offset_code <= inphase_offset_trim_q[`MOT_OFFSET_MSB:`MOT_OFFSET_LSB];
			o_quad_offset_code    <= quadrature_offset_trim_q[`MOT_OFFSET_MSB:`MOT_OFFSET_LSB];
			o_inphase_offset_mv   <=
				offset_mv(inphase_offset_trim_q[`MOT_OFFSET_MSB:`MOT_OFFSET_LSB]);
			o_quad_offset_mv      <=
				offset_mv(quadrature_offset_trim_q[`MOT_OFFSET_MSB:`MOT_OFFSET_LSB]);
			// invert only when both set
			// Mixed settings fall back to normal phase, the safe choice for an undefined code.
			o_if_phase_invert_sel <= test_and_if_invert_q[`MOT_INV_HI_BIT] &
				test_and_if_invert_q[`MOT_INV_LO_BIT];
			o_factory_test_bits   <= {test_and_if_invert_q[`MOT_TEST_HI_MSB:`MOT_TEST_HI_LSB],
				test_and_if_invert_q[`MOT_TEST_LO_MSB:`MOT_TEST_LO_LSB]};
		end
	end

endmodule
`default_nettype wire

// ### sim/mot_host_model.sv
// Host controller model that writes the trim registers.
`timescale 1ns/1ps
`default_nettype none
module mot_host_model (
	// Clock
	input  wire logic       i_clock,
	// Register write port
	output var  logic       o_wr_en,
	output var  logic [2:0] o_wr_addr,
	output var  logic [7:0] o_wr_data
);
	initial begin
		o_wr_en = 1'b0;
		o_wr_addr = 3'h0;
		o_wr_data = 8'h00;
	end
	// Calls in a row keep the strobe high, so writes go back to back.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_wr_en = 1'b1;
		o_wr_addr = a;
		o_wr_data = (a == 3'h5) ? (d & 8'h0c) : d;
	endtask
	task automatic idle;
		@(posedge i_clock);
		#1;
		o_wr_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### sim/mot_trim_regs_monitor.sv
// Checker for the trim register bank ports.
`timescale 1ns/1ps
`default_nettype none
module mot_trim_monitor (
	// Clock, reset and register port
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic        i_wr_en,
	input wire logic [2:0]  i_wr_addr,
	input wire logic [7:0]  i_wr_data,
	input wire logic [2:0]  i_rd_addr,
	input wire logic [7:0]  o_rd_data,
	// Decoded outputs
	input wire logic [3:0]  o_inphase_gain_code,
	input wire logic [3:0]  o_quad_gain_code,
	input wire logic [3:0]  o_envelope_gain_code,
	input wire logic [11:0] o_inphase_amp,
	input wire logic [11:0] o_envelope_amp,
	input wire logic [4:0]  o_inphase_offset_code,
	input wire logic [6:0]  o_inphase_offset_mv,
	input wire logic        o_if_phase_invert_sel
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	iq_gain_a: assert property (i_wr_en && i_wr_addr == 3'h1 |-> ##2
		{o_inphase_gain_code, o_quad_gain_code} == $past(i_wr_data, 2)) else $error("iq code");
	envelope_gain_code_a: assert property (i_wr_en && i_wr_addr == 3'h2 |-> ##2
		o_envelope_gain_code == $past(i_wr_data[7:4], 2)) else $error("env code");
	i_offset_a: assert property (i_wr_en && i_wr_addr == 3'h3 |-> ##2
		o_inphase_offset_code == $past(i_wr_data[7:3], 2)) else $error("offset code");
	invert_sel_a: assert property (i_wr_en && i_wr_addr == 3'h5 |-> ##2
		o_if_phase_invert_sel == ($past(i_wr_data[3:2], 2) == 2'b11)) else $error("invert");
	iq_amp_a: assert property (o_inphase_amp ==
		12'h3e8 + {{8{o_inphase_gain_code[3]}}, o_inphase_gain_code} * 12'h006) else $error("iq amp");
	env_amp_a: assert property (o_envelope_amp ==
		12'h3e8 + {{8{o_envelope_gain_code[3]}}, o_envelope_gain_code} * 12'h012) else $error("env amp");
	offset_mv_a: assert property (o_inphase_offset_mv ==
		{{2{o_inphase_offset_code[4]}}, o_inphase_offset_code} * 7'h03) else $error("offset mv");
	unmapped_rd_a: assert property (i_rd_addr == 3'h0 || i_rd_addr > 3'h5 |=>
		o_rd_data == 8'h00) else $error("unmapped read");
	cover property (o_if_phase_invert_sel);
	cover property (o_inphase_amp == 12'h412);
	cover property (o_envelope_amp == 12'h358);
endmodule
bind mot_trim_regs mot_trim_monitor u_mon (
	.i_clock               (i_clock),
	.i_reset               (i_reset),
	.i_wr_en               (i_wr_en),
	.i_wr_addr             (i_wr_addr),
	.i_wr_data             (i_wr_data),
	.i_rd_addr             (i_rd_addr),
	.o_rd_data             (o_rd_data),
	.o_inphase_gain_code   (o_inphase_gain_code),
	.o_quad_gain_code      (o_quad_gain_code),
	.o_envelope_gain_code  (o_envelope_gain_code),
	.o_inphase_amp         (o_inphase_amp),
	.o_envelope_amp        (o_envelope_amp),
	.o_inphase_offset_code (o_inphase_offset_code),
	.o_inphase_offset_mv   (o_inphase_offset_mv),
	.o_if_phase_invert_sel (o_if_phase_invert_sel)
);
`default_nettype wire

// ### sim/mot_trim_regs_tb_top.sv
// Self-checking testbench for the trim register bank.
`timescale 1ns/1ps
`default_nettype none
`include "mot_defines.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mot_trim_regs_tb_top;
	logic        i_clock = 1'b0;
	logic        i_reset = 1'b1;
	logic [2:0]  i_rd_addr = 3'h0;
	wire         i_wr_en, o_if_phase_invert_sel;
	wire  [2:0]  i_wr_addr;
	wire  [7:0]  i_wr_data, o_rd_data;
	wire  [3:0]  o_inphase_gain_code, o_quad_gain_code, o_envelope_gain_code;
	wire  [11:0] o_inphase_amp, o_quad_amp, o_envelope_amp;
	wire  [4:0]  o_inphase_offset_code, o_quad_offset_code;
	wire  [6:0]  o_inphase_offset_mv, o_quad_offset_mv;
	wire  [5:0]  o_factory_test_bits;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	mot_trim_regs DUT (
		.i_clock               (i_clock),
		.i_reset               (i_reset),
		.i_wr_en               (i_wr_en),
		.i_wr_addr             (i_wr_addr),
		.i_wr_data             (i_wr_data),
		.i_rd_addr             (i_rd_addr),
		.o_rd_data             (o_rd_data),
		.o_inphase_gain_code   (o_inphase_gain_code),
		.o_quad_gain_code      (o_quad_gain_code),
		.o_envelope_gain_code  (o_envelope_gain_code),
		.o_inphase_amp         (o_inphase_amp),
		.o_quad_amp            (o_quad_amp),
		.o_envelope_amp        (o_envelope_amp),
		.o_inphase_offset_code (o_inphase_offset_code),
		.o_quad_offset_code    (o_quad_offset_code),
		.o_inphase_offset_mv   (o_inphase_offset_mv),
		.o_quad_offset_mv      (o_quad_offset_mv),
		.o_if_phase_invert_sel (o_if_phase_invert_sel),
		.o_factory_test_bits   (o_factory_test_bits)
	);
	mot_host_model host (.i_clock(i_clock), .o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr),
		.o_wr_data(i_wr_data));
	always #5 i_clock = ~i_clock;
	// The sequence needs about 72 cycles; the ceiling leaves ample room.
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic load(input logic [63:0] w);
		for (int k = 0; k < 8; k++)
			host.wr(k[2:0], w[8*k +: 8]);
		host.idle();
	endtask
	// Expected trims from the step sizes: unity plus step times the signed code.
	function automatic logic [11:0] amp(input logic [3:0] c, input int s);
		int v;
		v = $signed(c);
		return 12'(1000 + v * s);
	endfunction
	function automatic logic [6:0] mv(input logic [4:0] c);
		int v;
		v = $signed(c);
		return 7'(3 * v);
	endfunction
	// The host clears the factory bits, so only the invert pair reaches the test register.
	task automatic verify(input logic [63:0] w);
		logic [7:0] m [0:7] = '{8'h00, `MOT_MASK_IQ_GAIN, `MOT_MASK_ENVELOPE_GAIN_CODE,
			`MOT_MASK_OFFSET, `MOT_MASK_OFFSET, 8'h0c, 8'h00, 8'h00};
		logic [7:0] d [0:7];
		for (int k = 0; k < 8; k++) begin
			d[k] = w[8*k +: 8] & m[k];
			i_rd_addr = k[2:0];
			@(posedge i_clock);
			#1;
			`CHK(o_rd_data, d[k])
		end
		`CHK({o_inphase_gain_code, o_quad_gain_code, o_envelope_gain_code, o_inphase_offset_code,
			o_quad_offset_code, o_if_phase_invert_sel, o_factory_test_bits}, {d[1], d[2][7:4],
			d[3][7:3], d[4][7:3], d[5][3:2] == 2'b11, 6'h00})
		`CHK({o_inphase_amp, o_quad_amp, o_envelope_amp},
			{amp(d[1][7:4], 6), amp(d[1][3:0], 6), amp(d[2][7:4], 18)})
		`CHK({o_inphase_offset_mv, o_quad_offset_mv}, {mv(d[3][7:3]), mv(d[4][7:3])})
	endtask
	initial begin
		repeat (20) @(posedge i_clock);
		#1;
		i_reset = 1'b0;
		verify(64'h0);
		load(64'hffff_ff87_7f8f_7fff);
		verify(64'hffff_ff87_7f8f_7fff);
		load(64'hffff_0400_ff7a_80ff);
		verify(64'hffff_0400_ff7a_80ff);
		i_reset = 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		i_reset = 1'b0;
		verify(64'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
